/* File: testbench/sep_host_model.sv */
`default_nettype none
// ********************
// Two-wire bus master model
// ********************
module sep_host_model (
  output logic scl, // Serial clock, stands high outside frames
  output logic pull_low, // High while the host pulls data low
  input wire logic sda // Resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime Q = 31.25; // Quarter of the 125 ns link period
  // Bus released and idle at time zero
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // One bit slot; data moves a quarter after the fall so it never looks like start or stop
  task automatic bit_slot(input logic b, output logic r);
    #Q pull_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    #Q pull_low = 1'b0;
    #Q scl = 1'b1;
    #Q pull_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high, clock then rests high
  task automatic stop();
    #Q pull_low = 1'b1;
    #Q scl = 1'b1;
    #Q pull_low = 1'b0;
    #Q;
  endtask
  // Byte out MSB first; returns the ninth-slot level, low when acknowledged
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_slot(d[i], ack);
    bit_slot(1'b1, ack);
  endtask
  // Byte in MSB first, then the host's answer: high on the last wanted byte
  task automatic recv(input logic last, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(last, x);
  endtask
endmodule // sep_host_model
`default_nettype wire

/* File: testbench/tb_serial_eeprom_page_write_read.sv */
`default_nettype none
// ********************
// Bench of the serial EEPROM engine
// ********************
module tb_serial_eeprom_page_write_read import sep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WR_CYC = 200; // Short programming cycle, still above 64
  logic core_clk = 1'b0; // Core clock
  logic resetn = 1'b0; // Reset, active low
  logic scl, pull_low, sda_o, sda_oe_n, write_busy, write_protect, sda;
  logic [1:0] strap; // Strapped address pins
  int failures = 0;
  int total_checks = 0;
  int seed = 39529;
  logic [7:0] mem [0:32767]; // Expected array, written places only
  logic [14:0] ptr; // Expected address counter
  // Line pulled up; any party pulling low wins
  assign sda = ~(pull_low | (~sda_oe_n & ~sda_o));
  always #5 core_clk = ~core_clk;
  sep_eeprom #(.WRITE_CYCLES(WR_CYC)) DUT (.core_clk(core_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .bus_select_pin_low(strap[0]), .bus_select_pin_high(strap[1]),
    .write_protect(write_protect), .write_busy(write_busy));
  sep_host_model host (.scl(scl), .pull_low(pull_low), .sda(sda));
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Device address byte for this strap
  function automatic logic [7:0] dev(input logic rd);
    return {SEP_DEV_PREFIX, strap, rd};
  endfunction
  // Device address plus both word address bytes
  task automatic addr(input logic [14:0] a);
    logic ack;
    host.start();
    host.send(dev(1'b0), ack);
    check("dev ack", ack, 1'b0);
    host.send({1'b0, a[14:8]}, ack);
    check("hi ack", ack, 1'b0);
    host.send(a[7:0], ack);
    check("lo ack", ack, 1'b0);
    ptr = a;
  endtask
  // Polling: the first try lands inside programming and must be refused
  task automatic poll();
    logic ack;
    for (int k = 0; k < 12; k++) begin
      host.start();
      host.send(dev(1'b0), ack);
      if (k == 0) begin
        check("busy", write_busy, 1'b1);
        check("poll nack", ack, 1'b1);
      end
      host.stop();
      if (ack === 1'b0) return;
    end
    check("poll done", ack, 1'b0);
  endtask
  // Page write of n random bytes, then wait for programming
  task automatic wr(input logic [14:0] a, input int n);
    logic ack;
    logic [7:0] d;
    addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      host.send(d, ack);
      check("data ack", ack, 1'b0);
      if (!write_protect) mem[{a[14:6], a[5:0] + 6'(i)}] = d;
    end
    host.stop();
    ptr = {a[14:6], a[5:0] + 6'(n)};
    poll();
  endtask
  // Read n bytes from the counter, acknowledging all but the last
  task automatic rd(input int n);
    logic ack;
    logic [7:0] d;
    host.start();
    host.send(dev(1'b1), ack);
    check("rd ack", ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      host.recv(i == n - 1, d);
      check("rd data", d, mem[ptr]);
      ptr = ptr + 15'h1;
    end
    host.stop();
  endtask
  // Main sequence
  initial begin
    logic [14:0] a;
    logic ack;
    logic [7:0] d;
    int n;
    write_protect = 1'b0;
    strap = 2'($random(seed));
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    check("idle oe", sda_oe_n, 1'b1);
    check("idle out", sda_o, 1'b0);
    check("idle busy", write_busy, 1'b0);
    // Over-long page write wraps inside the page, then read back
    a = 15'($random(seed));
    wr(a, 66);
    rd(1);
    addr({a[14:6], 6'h3a});
    rd(6);
    // Counter wraps at the top of the array
    wr(15'h7ffe, 2);
    wr(15'h0000, 2);
    addr(15'h7ffe);
    rd(4);
    // Protected write leaves the array alone
    @(posedge core_clk);
    #1 write_protect = 1'b1;
    wr(15'h0001, 1);
    @(posedge core_clk);
    #1 write_protect = 1'b0;
    addr(15'h0000);
    rd(2);
    // Random short writes read back by random reads
    for (int t = 0; t < 4; t++) begin
      a = 15'($random(seed)) & 15'h7fc7;
      n = 1 + ($random(seed) & 7);
      wr(a, n);
      addr(a);
      rd(n);
    end
    // Every strap value and a wrong prefix; only the match is answered
    for (int s = 0; s < 5; s++) begin
      host.start();
      host.send(s < 4 ? {SEP_DEV_PREFIX, 2'(s), 1'b1} : {5'h15, strap, 1'b1}, ack);
      check("strap", ack, (s < 4 && 2'(s) == strap) ? 1'b0 : 1'b1);
      if (ack === 1'b0) host.recv(1'b1, d);
      host.stop();
    end
    summarize();
  end
  // Watchdog, well beyond the expected run
  initial begin
    #600000;
    failures++;
    summarize();
  end
endmodule // tb_serial_eeprom_page_write_read
`default_nettype wire

/* File: verilog/sep_eeprom.sv */
// Operation
// - Up to 64 bytes per write, each acknowledged
// - Write advances only low six address bits
// - Page address wraps to page start
// - Address refused while programming runs
// - Read select bit high starts reads
// - Address counter holds last access plus one
// - Read counter wraps over whole array
// - Current read shifts out counter byte
// - Host ack advances to next byte
// - Sequential read wraps without pause
// - Device byte: prefix, two pins, direction
// - Two acknowledged word address bytes
// - Stop starts timed programming, inputs ignored
// - Write protect blocks all programming
`default_nettype none
// ****************************************************************
// Write path buffer
// ****************************************************************
module sep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain accepts
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage
  logic [AW:0] wp_q, rp_q; // Pointers with wrap bit
  assign in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data = mem_q[rp_q[AW-1:0]];
  // Pointers advance on accepted handshakes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid && in_ready) wp_q <= wp_q + 1'b1;
      if (out_valid && out_ready) rp_q <= rp_q + 1'b1;
    end
  end
  // Storage carries no reset
  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule // sep_fifo
// ****************************************************************
// Two-wire EEPROM target engine
// ****************************************************************
module sep_eeprom import sep_pkg::*; #(
  parameter int ADDR_W = SEP_ADDR_W,
  parameter int WRITE_CYCLES = SEP_WR_CYCLES
) (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin level
  output logic sda_o, // Data out, always low (open drain)
  output logic sda_oe_n, // Low while pulling data low
  input wire logic bus_select_pin_low, // Strapped address pin, low bit
  input wire logic bus_select_pin_high, // Strapped address pin, high bit
  input wire logic write_protect, // High blocks programming
  output logic write_busy // Programming cycle running
);
  initial if (ADDR_W <= SEP_PAGE_W || ADDR_W > 16 || WRITE_CYCLES < SEP_PAGE_BYTES) $error("bad parameters");
  // Device address byte compare
  function automatic logic dev_match(input logic [7:0] b, input logic [1:0] pins);
    dev_match = (b[7:3] == SEP_DEV_PREFIX) && (b[2:1] == pins);
  endfunction
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] scl_q, sda_q; // Two-stage sync plus history stage
  logic [1:0] sel1_q, sel2_q; // Address strap sync
  logic wp1_q, wp2_q; // Write protect sync
  // Pins pass two flops before use; third stage only gives edge history
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      sel1_q <= 2'h0;
      sel2_q <= 2'h0;
      wp1_q <= 1'b1;
      wp2_q <= 1'b1;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      sel1_q <= {bus_select_pin_high, bus_select_pin_low};
      sel2_q <= sel1_q;
      wp1_q <= write_protect;
      wp2_q <= wp1_q;
    end
  end
  wire logic sda_s = sda_q[1]; // Synchronised data level
  wire logic rise = scl_q[1] && !scl_q[2]; // Clock rise seen
  wire logic fall = !scl_q[1] && scl_q[2]; // Clock fall seen
  wire logic start_c = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1]; // Data falls while clock high
  wire logic stop_c = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1]; // Data rises while clock high
  // ****************************************************************
  // Byte protocol
  // ****************************************************************
  sep_state_t state_q; // Protocol state
  logic [3:0] cnt_q; // Bit within byte, 8 is the ack slot
  logic [7:0] sh_q, hi_q, tx_q; // Shift in, address high, shift out
  logic [ADDR_W-1:0] ctr_q; // Word address counter
  logic ack_q, wrote_q, pend_q, busy_q, in_ready, out_valid; // Ack, data taken, commit pending, busy, buffer flags
  wire logic [7:0] nb = {sh_q[6:0], sda_s}; // Byte completed at eighth clock
  wire logic push = rise && state_q == SEP_WDATA && cnt_q == SEP_BIT_ACK && ack_q; // Data byte into buffer
  sep_wr_t out_word; // Buffer output
  logic [7:0] mem [1 << ADDR_W]; // The array
  // Start, shift, acknowledge decision and state walk
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= SEP_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      hi_q <= 8'h00;
      tx_q <= 8'hff;
      ctr_q <= '0;
      ack_q <= 1'b0;
      wrote_q <= 1'b0;
    end else if (start_c) begin
      state_q <= SEP_DEV;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= SEP_IDLE;
      wrote_q <= 1'b0;
    end else if (rise && state_q != SEP_IDLE) begin
      if (cnt_q != SEP_BIT_ACK) begin
        sh_q <= nb;
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == SEP_BIT_LAST) begin
          case (state_q)
            SEP_DEV: ack_q <= dev_match(nb, sel2_q) && !busy_q && !pend_q;
            SEP_WDATA: ack_q <= in_ready;
            SEP_RDATA: ack_q <= 1'b0;
            default: ack_q <= 1'b1;
          endcase
        end
      end else begin
        cnt_q <= 4'h0;
        case (state_q)
          SEP_DEV: begin
            if (!ack_q) state_q <= SEP_IDLE;
            else if (sh_q[0]) begin
              state_q <= SEP_RDATA;
              tx_q <= mem[ctr_q];
              ctr_q <= ctr_q + 1'b1;
            end else state_q <= SEP_ADDR_HI;
          end
          SEP_ADDR_HI: begin
            hi_q <= sh_q;
            state_q <= SEP_ADDR_LO;
          end
          SEP_ADDR_LO: begin
            ctr_q <= ADDR_W'({hi_q, sh_q});
            state_q <= SEP_WDATA;
          end
          SEP_WDATA: begin
            if (ack_q) begin
              wrote_q <= 1'b1;
              ctr_q[SEP_PAGE_W-1:0] <= ctr_q[SEP_PAGE_W-1:0] + 1'b1;
            end else state_q <= SEP_IDLE;
          end
          SEP_RDATA: begin
            if (!sda_s) begin
              tx_q <= mem[ctr_q];
              ctr_q <= ctr_q + 1'b1;
            end else state_q <= SEP_IDLE; // Host nack ends the read
          end
          default: state_q <= SEP_IDLE;
        endcase
      end
    end
  end
  // Data line drive, changed after a clock fall, released on start or stop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
    end else if (start_c || stop_c) sda_oe_n <= 1'b1;
    else if (fall) begin
      if (state_q == SEP_RDATA && cnt_q != SEP_BIT_ACK) sda_oe_n <= tx_q[3'h7 - cnt_q[2:0]];
      else sda_oe_n <= !(cnt_q == SEP_BIT_ACK && ack_q);
    end
  end
  // ****************************************************************
  // Page latch and programming
  // ****************************************************************
  logic [7:0] pg_q [SEP_PAGE_BYTES]; // Page latch
  logic [SEP_PAGE_BYTES-1:0] mask_q; // Slots written in this write
  logic [SEP_PAGE_W:0] ci_q; // Commit index
  logic [$clog2(WRITE_CYCLES)-1:0] tmr_q; // Write cycle timer
  wire logic mem_we = busy_q && !ci_q[SEP_PAGE_W] && mask_q[ci_q[SEP_PAGE_W-1:0]] && !wp2_q;
  // Buffer decouples bus bytes from the latch; it drains whenever no programming cycle runs, also during bus transfers
  sep_fifo #(.WIDTH($bits(sep_wr_t)), .DEPTH(SEP_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data({ctr_q[SEP_PAGE_W-1:0], sh_q}),
    .out_valid(out_valid),
    .out_ready(!busy_q),
    .out_data(out_word)
  );
  assign write_busy = busy_q; // Output taken straight from the programming flop
  // Stop arms the commit; the cycle begins once the buffer is empty
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      ci_q <= '0;
      tmr_q <= '0;
      mask_q <= '0;
    end else begin
      if (stop_c && wrote_q) pend_q <= 1'b1;
      else if (pend_q && !out_valid) begin
        pend_q <= 1'b0;
        busy_q <= 1'b1;
        ci_q <= '0;
        tmr_q <= '0;
      end
      if (out_valid && !busy_q) mask_q[out_word.idx] <= 1'b1;
      if (busy_q) begin
        if (!ci_q[SEP_PAGE_W]) ci_q <= ci_q + 1'b1;
        tmr_q <= tmr_q + 1'b1;
        if (tmr_q == ($clog2(WRITE_CYCLES))'(WRITE_CYCLES - 1)) begin
          busy_q <= 1'b0;
          mask_q <= '0;
        end
      end
    end
  end
  // Latch and array storage
  always_ff @(posedge core_clk) begin
    if (out_valid && !busy_q) pg_q[out_word.idx] <= out_word.data;
    if (mem_we) mem[{ctr_q[ADDR_W-1:SEP_PAGE_W], ci_q[SEP_PAGE_W-1:0]}] <= pg_q[ci_q[SEP_PAGE_W-1:0]];
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_busy_nack;
    rise && state_q == SEP_DEV && cnt_q == SEP_BIT_LAST && (busy_q || pend_q) |=> !ack_q;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");
  property p_dev_mismatch;
    rise && state_q == SEP_DEV && cnt_q == SEP_BIT_LAST && !dev_match(nb, sel2_q) |=> !ack_q;
  endproperty
  a_dev_mismatch: assert property (p_dev_mismatch) else $error("foreign address acked");
  property p_page_inc;
    push |=> ctr_q[ADDR_W-1:SEP_PAGE_W] == $past(ctr_q[ADDR_W-1:SEP_PAGE_W])
      && ctr_q[SEP_PAGE_W-1:0] == $past(ctr_q[SEP_PAGE_W-1:0]) + 6'h1;
  endproperty
  a_page_inc: assert property (p_page_inc) else $error("page address step wrong");
  property p_page_wrap;
    push && ctr_q[SEP_PAGE_W-1:0] == 6'h3f |=> ctr_q[SEP_PAGE_W-1:0] == 6'h00;
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page did not wrap");
  property p_read_wrap;
    rise && state_q == SEP_RDATA && cnt_q == SEP_BIT_ACK && !sda_s && (&ctr_q) |=> ctr_q == '0;
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("array did not wrap");
  property p_seq_next;
    rise && state_q == SEP_RDATA && cnt_q == SEP_BIT_ACK && !sda_s
      |=> state_q == SEP_RDATA && ctr_q == $past(ctr_q) + 1'b1;
  endproperty
  a_seq_next: assert property (p_seq_next) else $error("sequential read stalled");
  property p_busy_hold;
    $rose(busy_q) |-> !out_valid ##1 busy_q [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("write cycle too short");
  property p_protect;
    mem_we |-> !wp2_q && busy_q;
  endproperty
  a_protect: assert property (p_protect) else $error("protected array written");
  property p_ack_drive;
    fall && !start_c && !stop_c && cnt_q == SEP_BIT_ACK && ack_q |=> !sda_oe_n;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");
  c_page_write: cover property ($rose(busy_q));
  c_seq_read: cover property (rise && state_q == SEP_RDATA && cnt_q == SEP_BIT_ACK && !sda_s);
  c_poll_nack: cover property (rise && state_q == SEP_DEV && cnt_q == SEP_BIT_LAST && busy_q);
endmodule // sep_eeprom
`default_nettype wire

/* File: verilog/sep_pkg.sv */
`default_nettype none
// ****************************************************************
// Shared constants and types of the serial EEPROM engine
// ****************************************************************
package sep_pkg;
  localparam int SEP_ADDR_W = 15;                  // Byte address width of the array
  localparam int SEP_PAGE_W = 6;                   // In-page address bits
  localparam int SEP_PAGE_BYTES = 64;              // Bytes in one page
  localparam logic [4:0] SEP_DEV_PREFIX = 5'h14;   // Fixed one-zero pattern 10100
  localparam int SEP_CLK_NS = 10;                  // Core clock period
  localparam int SEP_WR_TIME_US = 5000;            // Self-timed write cycle, longest
  localparam int SEP_WR_CYCLES = SEP_WR_TIME_US * 1000 / SEP_CLK_NS; // Rounded down
  localparam int SEP_FIFO_DEPTH = 16;              // Words buffered on the write path
  localparam logic [3:0] SEP_BIT_ACK = 4'h8;       // Bit count of the ninth clock
  localparam logic [3:0] SEP_BIT_LAST = 4'h7;      // Bit count of the eighth clock
  // Bus engine states
  typedef enum logic [2:0] {SEP_IDLE, SEP_DEV, SEP_ADDR_HI, SEP_ADDR_LO, SEP_WDATA, SEP_RDATA} sep_state_t;
  // Received byte with its in-page slot
  typedef struct packed {
    logic [SEP_PAGE_W-1:0] idx;
    logic [7:0] data;
  } sep_wr_t;
endpackage
`default_nettype wire
